// ===== rtl/pib_defines.svh
`ifndef PIB_DEFINES_SVH
`define PIB_DEFINES_SVH

`define PIB_ADDR_W 8
`define PIB_REG_BRIDGE_CTRL 8'h52
`define PIB_REG_IDE_TIMING 8'h43
`define PIB_REG_STATUS 8'h60
`define PIB_BRIDGE_CTRL_RST 8'h00
`define PIB_IDE_TIMING_RST 8'h00
`define PIB_BIT_LATCH_EN 7
`define PIB_BIT_SLOT_AEN 6
`define PIB_BIT_BUF_EN 4
`define PIB_BIT_HOT_INS 3
`define PIB_IDE0_LO 0
`define PIB_IDE0_HI 3
`define PIB_IDE1_LO 4
`define PIB_IDE1_HI 7
`define PIB_CLK_PERIOD_NS 5
`define PIB_CLKRUN_HOLD_NS 10
`define PIB_CLKRUN_HOLD_CYC ((`PIB_CLKRUN_HOLD_NS + `PIB_CLK_PERIOD_NS - 1) / `PIB_CLK_PERIOD_NS)
`define PIB_CNT_W 4
`define PIB_DACK_RST 8'hFF
`define PIB_DACK_OE_IDLE 8'h10
`define PIB_DACK_CODE_HI 2
`define PIB_DACK_EXTRA_PCI_REQUEST0_N 3
`define PIB_DACK_EXTRA_PCI_GRANT0_N 5
`define PIB_DACK_REQ1 6
`define PIB_DACK_GNT1 7

`endif

// ===== rtl/pib_pkg.sv
package pib_pkg;

	typedef enum logic [1:0] {
		PIB_CR_IDLE = 2'b00,
		PIB_CR_DRIVE = 2'b01,
		PIB_CR_WAIT = 2'b10
	} pib_clkrun_t;

	typedef struct packed {
		logic [7:0] bridge_ctrl;
		logic [7:0] ide_timing;
		logic [7:0] rdata;
		pib_clkrun_t cr_state;
		logic [3:0] cr_count;
		logic clkrun_oe_n;
		logic ad_oe_n;
		logic cbe_oe_n;
		logic par_oe_n;
		logic frame_oe_n;
		logic irdy_oe_n;
		logic trdy_oe_n;
		logic stop_oe_n;
		logic devsel_oe_n;
		logic perr_oe_n;
		logic serr_oe_n;
		logic lock_oe_n;
		logic drive_low;
		logic req_n;
		logic bus_owned;
		logic sa_oe_n;
		logic [15:0] sa_low_out;
		logic rstdrv_pin;
		logic hot_drive_insert_n;
		logic chan_check_n;
		logic ide_cable0_dma_request;
		logic ide_cable1_dma_request;
		logic no_wait_n;
		logic dreq7;
		logic strobe0_pin;
		logic strobe1_pin;
		logic strobe_oe_n;
		logic [7:0] dack_out_n;
		logic [7:0] dack_oe_n;
		logic aen_pin;
		logic extra_pci_request0_n;
		logic extra_pci_request1_n;
	} pib_state_t;

endpackage

// ===== rtl/pib_strap_sense.sv
`timescale 1ns/1ps
`default_nettype none

module pib_strap_sense #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] strap_in,
	output logic [WIDTH-1:0] strap_out,
	output logic done
);

	// Caught on the first edge after release, never under reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			strap_out <= '0;
			done <= 1'b0;
		end else if (!done) begin
			strap_out <= strap_in;
			done <= 1'b1;
		end
	end

endmodule // pib_strap_sense

`default_nettype wire

// ===== rtl/pib_pin_control.sv
// Behaviour
// - Address phase: AD input for outside master
// - Data phase: AD input on writes in, own reads
// - Command/byte enables driven except outside master cycle
// - Clock-run held low to keep or restart clock
// - Parity input on incoming address/write, own reads
// - Frame and initiator-ready driven only when mastering
// - Target-ready driven for outside access to ISA/config
// - Stop driven as target to end transaction
// - Device-select driven only when claiming access
// - Config space open only with ID select
// - Parity-error driven on target writes, own reads
// - System-error pulled low on address parity, special-cycle data parity or fatal errors
// - Lock line never driven, always input
// - Bus request for DMA memory or driveback
// - ISA address driven unless outside ISA master outside a power latch cycle
// - Low ISA address carries power latch bits
// - Control bit 7 makes reset pin latch enable
// - Control bit 3 makes channel check hot-insert
// - IDE byte low nibble makes no-wait cable-0 request
// - IDE byte high nibble makes DMA7 cable-1 request
// - Control bit 4 makes strobes buffer enables
// - Drive-read strap selects extended acknowledge mode
`timescale 1ns/1ps
`default_nettype none
`include "pib_defines.svh"

module pib_pin_control (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic idsel,
	input wire logic pci_addr_phase,
	input wire logic pci_data_phase,
	input wire logic ext_master_cycle,
	input wire logic ext_write,
	input wire logic own_master_cycle,
	input wire logic own_read,
	input wire logic target_isa_or_cfg,
	input wire logic target_claim_pos,
	input wire logic target_claim_sub,
	input wire logic target_stop_req,
	input wire logic data_parity_err,
	input wire logic addr_parity_err,
	input wire logic special_cycle,
	input wire logic fatal_err,
	input wire logic dma_mem_need,
	input wire logic driveback_need,
	input wire logic gnt_n,
	input wire logic clkrun_in_n,
	input wire logic clock_keep_req,
	input wire logic isa_ext_master,
	input wire logic power_latch_cycle,
	input wire logic [15:0] power_latch_bits,
	input wire logic [15:0] isa_addr_low,
	input wire logic isa_reset_drive,
	input wire logic power_latch_enable,
	input wire logic chck_pin_n,
	input wire logic nows_pin_n,
	input wire logic drq7_pin,
	input wire logic drive_read_strobe_n,
	input wire logic drive_write_strobe_n,
	input wire logic ide_cable0_buffer_en_n,
	input wire logic ide_cable1_buffer_en_n,
	input wire logic drive_read_pin_in,
	input wire logic [7:0] dack_n,
	input wire logic [2:0] encoded_ack,
	input wire logic [7:0] dack_pin_in,
	input wire logic extra_pci_grant0_n,
	input wire logic extra_pci_grant1_n,
	input wire logic aen_in,
	input wire logic slot1_address_enable,
	input wire logic slot2_address_enable,
	input wire logic slot3_address_enable,
	output logic clkrun_oe_n,
	output logic ad_oe_n,
	output logic cbe_oe_n,
	output logic par_oe_n,
	output logic frame_oe_n,
	output logic irdy_oe_n,
	output logic trdy_oe_n,
	output logic stop_oe_n,
	output logic devsel_oe_n,
	output logic perr_oe_n,
	output logic perr_out_n,
	output logic serr_oe_n,
	output logic serr_out_n,
	output logic lock_oe_n,
	output logic req_n,
	output logic bus_owned,
	output logic sa_oe_n,
	output logic [15:0] sa_low_out,
	output logic rstdrv_pin,
	output logic hot_drive_insert_n,
	output logic chan_check_n,
	output logic ide_cable0_dma_request,
	output logic ide_cable1_dma_request,
	output logic no_wait_n,
	output logic dreq7,
	output logic strobe0_pin,
	output logic strobe1_pin,
	output logic strobe_oe_n,
	output logic [7:0] dack_out_n,
	output logic [7:0] dack_oe_n,
	output logic aen_pin,
	output logic extra_pci_request0_n,
	output logic extra_pci_request1_n,
	output logic extended_mode,
	output logic strap_done
);

	localparam logic [3:0] HOLD_CYC = 4'(`PIB_CLKRUN_HOLD_CYC);

	pib_pkg::pib_state_t s_reg;
	pib_pkg::pib_state_t s_next;
	logic ext_mode_w;
	logic strap_done_w;
	logic slot_mode;
	logic cfg_wr;
	logic cfg_rd;

	// Strap pin floats while sensed; drive strobe stays released until done
	pib_strap_sense #(
		.WIDTH(1)
	) u_strap (
		.clk(clk),
		.resetn(resetn),
		.strap_in(drive_read_pin_in),
		.strap_out(ext_mode_w),
		.done(strap_done_w)
	);

	assign slot_mode = s_reg.bridge_ctrl[`PIB_BIT_SLOT_AEN];
	assign cfg_wr = reg_wr && idsel;
	assign cfg_rd = reg_rd && idsel;

	always_comb begin
		s_next = s_reg;
		if (cfg_wr && reg_addr == `PIB_REG_BRIDGE_CTRL) begin
			s_next.bridge_ctrl = reg_wdata;
		end
		if (cfg_wr && reg_addr == `PIB_REG_IDE_TIMING) begin
			s_next.ide_timing = reg_wdata;
		end
		s_next.rdata = 8'h00;
		if (cfg_rd) begin
			case (reg_addr)
				`PIB_REG_BRIDGE_CTRL: s_next.rdata = s_reg.bridge_ctrl;
				`PIB_REG_IDE_TIMING: s_next.rdata = s_reg.ide_timing;
				`PIB_REG_STATUS: s_next.rdata = {strap_done_w, ext_mode_w, s_reg.cr_state,
					s_reg.bus_owned, s_reg.req_n, s_reg.clkrun_oe_n, s_reg.sa_oe_n};
				default: s_next.rdata = 8'h00;
			endcase
		end

		// Clock stop hold-off or restart request
		case (s_reg.cr_state)
			pib_pkg::PIB_CR_IDLE: begin
				if (clock_keep_req && clkrun_in_n) begin
					s_next.cr_state = pib_pkg::PIB_CR_DRIVE;
					s_next.cr_count = HOLD_CYC - 4'h1;
				end
			end
			pib_pkg::PIB_CR_DRIVE: begin
				if (s_reg.cr_count == 4'h0) begin
					s_next.cr_state = pib_pkg::PIB_CR_WAIT;
				end else begin
					s_next.cr_count = s_reg.cr_count - 4'h1;
				end
			end
			pib_pkg::PIB_CR_WAIT: begin
				// Wait for the host to own the line again before a new request
				if (!clkrun_in_n) begin
					s_next.cr_state = pib_pkg::PIB_CR_IDLE;
				end
			end
			default: s_next.cr_state = pib_pkg::PIB_CR_IDLE;
		endcase
		s_next.clkrun_oe_n = (s_next.cr_state != pib_pkg::PIB_CR_DRIVE);

		if (pci_addr_phase) begin
			s_next.ad_oe_n = ext_master_cycle;
		end else if (pci_data_phase) begin
			s_next.ad_oe_n = (ext_master_cycle && ext_write) || (own_master_cycle && own_read);
		end else begin
			s_next.ad_oe_n = 1'b0;
		end
		s_next.cbe_oe_n = ext_master_cycle;
		s_next.par_oe_n = (ext_master_cycle && (pci_addr_phase || (pci_data_phase && ext_write)))
			|| (own_master_cycle && own_read && pci_data_phase);
		s_next.frame_oe_n = !own_master_cycle;
		s_next.irdy_oe_n = !own_master_cycle;
		s_next.trdy_oe_n = !(ext_master_cycle && target_isa_or_cfg);
		s_next.stop_oe_n = !(ext_master_cycle && target_stop_req);
		s_next.devsel_oe_n = !(ext_master_cycle && (target_claim_pos || target_claim_sub));
		s_next.perr_oe_n = !(data_parity_err && pci_data_phase && !special_cycle
			&& ((ext_master_cycle && ext_write) || (own_master_cycle && own_read)));
		s_next.serr_oe_n = !(addr_parity_err || (data_parity_err && special_cycle) || fatal_err);
		s_next.lock_oe_n = 1'b1;
		s_next.drive_low = 1'b0;
		s_next.req_n = !(dma_mem_need || driveback_need);
		s_next.bus_owned = !gnt_n;

		s_next.sa_oe_n = isa_ext_master && !power_latch_cycle;
		s_next.sa_low_out = power_latch_cycle ? power_latch_bits : isa_addr_low;
		s_next.rstdrv_pin = s_reg.bridge_ctrl[`PIB_BIT_LATCH_EN] ? power_latch_enable : isa_reset_drive;
		if (s_reg.bridge_ctrl[`PIB_BIT_HOT_INS]) begin
			s_next.hot_drive_insert_n = chck_pin_n;
			s_next.chan_check_n = 1'b1;
		end else begin
			s_next.hot_drive_insert_n = 1'b1;
			s_next.chan_check_n = chck_pin_n;
		end
		if (|s_reg.ide_timing[`PIB_IDE0_HI:`PIB_IDE0_LO]) begin
			s_next.ide_cable0_dma_request = !nows_pin_n;
			s_next.no_wait_n = 1'b1;
		end else begin
			s_next.ide_cable0_dma_request = 1'b0;
			s_next.no_wait_n = nows_pin_n;
		end
		if (|s_reg.ide_timing[`PIB_IDE1_HI:`PIB_IDE1_LO]) begin
			s_next.ide_cable1_dma_request = drq7_pin;
			s_next.dreq7 = 1'b0;
		end else begin
			s_next.ide_cable1_dma_request = 1'b0;
			s_next.dreq7 = drq7_pin;
		end
		if (s_reg.bridge_ctrl[`PIB_BIT_BUF_EN]) begin
			s_next.strobe0_pin = ide_cable0_buffer_en_n;
			s_next.strobe1_pin = ide_cable1_buffer_en_n;
		end else begin
			s_next.strobe0_pin = drive_read_strobe_n;
			s_next.strobe1_pin = drive_write_strobe_n;
		end
		s_next.strobe_oe_n = !strap_done_w;

		// Pin 4 of the acknowledge group does not exist and stays released
		s_next.dack_out_n = dack_n;
		s_next.dack_oe_n = `PIB_DACK_OE_IDLE;
		s_next.extra_pci_request0_n = 1'b1;
		s_next.extra_pci_request1_n = 1'b1;
		if (ext_mode_w) begin
			s_next.dack_out_n[`PIB_DACK_CODE_HI:0] = encoded_ack;
			s_next.dack_oe_n[`PIB_DACK_EXTRA_PCI_REQUEST0_N] = 1'b1;
			s_next.dack_out_n[`PIB_DACK_EXTRA_PCI_REQUEST0_N] = 1'b1;
			s_next.dack_out_n[`PIB_DACK_EXTRA_PCI_GRANT0_N] = extra_pci_grant0_n;
			s_next.dack_oe_n[`PIB_DACK_REQ1] = 1'b1;
			s_next.dack_out_n[`PIB_DACK_REQ1] = 1'b1;
			s_next.dack_out_n[`PIB_DACK_GNT1] = extra_pci_grant1_n;
			s_next.extra_pci_request0_n = dack_pin_in[`PIB_DACK_EXTRA_PCI_REQUEST0_N];
			s_next.extra_pci_request1_n = slot_mode ? 1'b1 : dack_pin_in[`PIB_DACK_REQ1];
		end
		s_next.aen_pin = aen_in;
		if (slot_mode) begin
			s_next.aen_pin = slot1_address_enable;
			s_next.dack_out_n[`PIB_DACK_GNT1] = slot2_address_enable;
			s_next.dack_out_n[`PIB_DACK_REQ1] = slot3_address_enable;
			s_next.dack_oe_n[`PIB_DACK_REQ1] = 1'b0;
		end

		if (!resetn) begin
			s_next = '0;
			s_next.bridge_ctrl = `PIB_BRIDGE_CTRL_RST;
			s_next.ide_timing = `PIB_IDE_TIMING_RST;
			s_next.cr_state = pib_pkg::PIB_CR_IDLE;
			s_next.clkrun_oe_n = 1'b1;
			s_next.ad_oe_n = 1'b1;
			s_next.cbe_oe_n = 1'b1;
			s_next.par_oe_n = 1'b1;
			s_next.frame_oe_n = 1'b1;
			s_next.irdy_oe_n = 1'b1;
			s_next.trdy_oe_n = 1'b1;
			s_next.stop_oe_n = 1'b1;
			s_next.devsel_oe_n = 1'b1;
			s_next.perr_oe_n = 1'b1;
			s_next.serr_oe_n = 1'b1;
			s_next.lock_oe_n = 1'b1;
			s_next.req_n = 1'b1;
			s_next.sa_oe_n = 1'b1;
			s_next.hot_drive_insert_n = 1'b1;
			s_next.chan_check_n = 1'b1;
			s_next.no_wait_n = 1'b1;
			s_next.strobe0_pin = 1'b1;
			s_next.strobe1_pin = 1'b1;
			s_next.strobe_oe_n = 1'b1;
			s_next.dack_out_n = `PIB_DACK_RST;
			s_next.dack_oe_n = `PIB_DACK_RST;
			s_next.extra_pci_request0_n = 1'b1;
			s_next.extra_pci_request1_n = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign reg_rdata = s_reg.rdata;
	assign clkrun_oe_n = s_reg.clkrun_oe_n;
	assign ad_oe_n = s_reg.ad_oe_n;
	assign cbe_oe_n = s_reg.cbe_oe_n;
	assign par_oe_n = s_reg.par_oe_n;
	assign frame_oe_n = s_reg.frame_oe_n;
	assign irdy_oe_n = s_reg.irdy_oe_n;
	assign trdy_oe_n = s_reg.trdy_oe_n;
	assign stop_oe_n = s_reg.stop_oe_n;
	assign devsel_oe_n = s_reg.devsel_oe_n;
	assign perr_oe_n = s_reg.perr_oe_n;
	assign perr_out_n = s_reg.drive_low;
	assign serr_oe_n = s_reg.serr_oe_n;
	assign serr_out_n = s_reg.drive_low;
	assign lock_oe_n = s_reg.lock_oe_n;
	assign req_n = s_reg.req_n;
	assign bus_owned = s_reg.bus_owned;
	assign sa_oe_n = s_reg.sa_oe_n;
	assign sa_low_out = s_reg.sa_low_out;
	assign rstdrv_pin = s_reg.rstdrv_pin;
	assign hot_drive_insert_n = s_reg.hot_drive_insert_n;
	assign chan_check_n = s_reg.chan_check_n;
	assign ide_cable0_dma_request = s_reg.ide_cable0_dma_request;
	assign ide_cable1_dma_request = s_reg.ide_cable1_dma_request;
	assign no_wait_n = s_reg.no_wait_n;
	assign dreq7 = s_reg.dreq7;
	assign strobe0_pin = s_reg.strobe0_pin;
	assign strobe1_pin = s_reg.strobe1_pin;
	assign strobe_oe_n = s_reg.strobe_oe_n;
	assign dack_out_n = s_reg.dack_out_n;
	assign dack_oe_n = s_reg.dack_oe_n;
	assign aen_pin = s_reg.aen_pin;
	assign extra_pci_request0_n = s_reg.extra_pci_request0_n;
	assign extra_pci_request1_n = s_reg.extra_pci_request1_n;
	assign extended_mode = ext_mode_w;
	assign strap_done = strap_done_w;

	addr_phase_dir_a: assert property (@(posedge clk) disable iff (!resetn)
		pci_addr_phase |=> (ad_oe_n == $past(ext_master_cycle)))
		else $error("AD direction wrong in address phase");

	cbe_dir_a: assert property (@(posedge clk) disable iff (!resetn)
		ext_master_cycle ##1 !ext_master_cycle |-> cbe_oe_n ##1 !cbe_oe_n)
		else $error("Byte enables not released to outside master");

	clkrun_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(clkrun_oe_n) |-> !clkrun_oe_n[*2] ##1 clkrun_oe_n)
		else $error("Clock-run drive length wrong");

	frame_only_master_a: assert property (@(posedge clk) disable iff (!resetn)
		!frame_oe_n |-> $past(own_master_cycle) && !irdy_oe_n)
		else $error("Frame driven while not mastering");

	devsel_claim_a: assert property (@(posedge clk) disable iff (!resetn)
		(ext_master_cycle && (target_claim_pos || target_claim_sub)) |=> !devsel_oe_n)
		else $error("Device select not driven on claim");

	cfg_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		(reg_wr && !idsel && reg_addr == `PIB_REG_BRIDGE_CTRL) |=> $stable(s_reg.bridge_ctrl))
		else $error("Config write without ID select");

	perr_special_a: assert property (@(posedge clk) disable iff (!resetn)
		special_cycle |=> perr_oe_n)
		else $error("Parity error driven in special cycle");

	serr_low_a: assert property (@(posedge clk) disable iff (!resetn)
		!serr_oe_n |-> !serr_out_n && $past(addr_parity_err || fatal_err || (data_parity_err && special_cycle)))
		else $error("System error driven without cause");

	lock_input_a: assert property (@(posedge clk) disable iff (!resetn)
		lock_oe_n)
		else $error("Lock line driven");

	req_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		(dma_mem_need || driveback_need) |=> !req_n)
		else $error("Bus request missing");

	latch_mux_a: assert property (@(posedge clk) disable iff (!resetn)
		power_latch_cycle |=> sa_low_out == $past(power_latch_bits) && !sa_oe_n)
		else $error("Power latch bits not on address");

	slot_aen_a: assert property (@(posedge clk) disable iff (!resetn)
		(slot_mode && $stable(slot_mode)) |=> aen_pin == $past(slot1_address_enable))
		else $error("Slot address enable not routed");

endmodule // pib_pin_control

`default_nettype wire

// ===== test/pib_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pib_host_model #(
	parameter int GRANT_DLY = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_n,
	input wire logic clkrun_oe_n,
	input wire logic stop_pending,
	output logic gnt_n = 1'b1,
	output logic clkrun_in_n
);
	int wait_cnt;
	// Slow grant, so a request that drops early is caught
	always @(posedge clk) begin
		if (!resetn || req_n) begin
			wait_cnt <= 0;
			gnt_n <= 1'b1;
		end else if (wait_cnt == GRANT_DLY) begin
			gnt_n <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	// Pulled up once the host lets go; held low while the clock runs
	assign clkrun_in_n = stop_pending ? clkrun_oe_n : 1'b0;
endmodule // pib_host_model
`default_nettype wire

// ===== test/pib_pin_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pib_defines.svh"

module pib_pin_control_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, idsel = 1'b1, stop_pending = 1'b0;
	logic pci_addr_phase = 1'b0, pci_data_phase = 1'b0, ext_master_cycle = 1'b0, ext_write = 1'b0;
	logic own_master_cycle = 1'b0, own_read = 1'b0, target_isa_or_cfg = 1'b0, target_claim_pos = 1'b0;
	logic target_claim_sub = 1'b0, target_stop_req = 1'b0, data_parity_err = 1'b0, addr_parity_err = 1'b0;
	logic special_cycle = 1'b0, fatal_err = 1'b0, dma_mem_need = 1'b0, driveback_need = 1'b0;
	logic clock_keep_req = 1'b0, isa_ext_master = 1'b0, power_latch_cycle = 1'b0, isa_reset_drive = 1'b0;
	logic power_latch_enable = 1'b0, chck_pin_n = 1'b1, nows_pin_n = 1'b1, drq7_pin = 1'b0;
	logic drive_read_strobe_n = 1'b1, drive_write_strobe_n = 1'b1, ide_cable0_buffer_en_n = 1'b1;
	logic ide_cable1_buffer_en_n = 1'b1, drive_read_pin_in = 1'b0, aen_in = 1'b0, slot1_address_enable = 1'b0;
	logic slot2_address_enable = 1'b0, slot3_address_enable = 1'b0;
	logic extra_pci_grant0_n = 1'b1, extra_pci_grant1_n = 1'b1;
	logic [15:0] power_latch_bits = 16'h0000, isa_addr_low = 16'h0000, sa_low_out;
	logic [7:0] dack_n = 8'hFF, dack_pin_in = 8'hFF, dack_out_n, dack_oe_n;
	logic [2:0] encoded_ack = 3'h0;
	logic gnt_n, clkrun_in_n, clkrun_oe_n, ad_oe_n, cbe_oe_n, par_oe_n, frame_oe_n, irdy_oe_n, trdy_oe_n;
	logic stop_oe_n, devsel_oe_n, perr_oe_n, perr_out_n, serr_oe_n, serr_out_n, lock_oe_n, req_n, bus_owned;
	logic sa_oe_n, rstdrv_pin, hot_drive_insert_n, chan_check_n, ide_cable0_dma_request, ide_cable1_dma_request;
	logic no_wait_n, dreq7, strobe0_pin, strobe1_pin, strobe_oe_n, aen_pin, extra_pci_request0_n;
	logic extra_pci_request1_n, extended_mode, strap_done;
	logic [7:0] cfg52 [9] = '{8'h00, 8'h80, 8'h08, 8'h10, 8'h40, 8'hD8, 8'h00, 8'h80, 8'h08};
	logic [7:0] cfg43 [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
	int num_errors = 0;
	int checked = 0;
	int n;

	pib_pin_control dut (.*);
	pib_host_model #(.GRANT_DLY(3)) host (.*);

	always #2.5 clk = ~clk;

	task automatic summarize();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Outputs land one edge after the inputs, so look just past the next edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(nm, 16'(e), 16'(reg_rdata));
	endtask

	task automatic strap_case(input logic s);
		@(posedge clk);
		{resetn, drive_read_pin_in} <= {1'b0, s};
		repeat (8) @(posedge clk);
		#1 chk("reset_oe", 16'h0FFF, 16'({ad_oe_n, cbe_oe_n, par_oe_n, frame_oe_n, irdy_oe_n, trdy_oe_n,
			stop_oe_n, devsel_oe_n, perr_oe_n, serr_oe_n, lock_oe_n, req_n}));
		@(posedge clk);
		resetn <= 1'b1;
		step();
		chk("strap", 16'({1'b1, s}), 16'({strap_done, extended_mode}));
		@(posedge clk);
		{dack_n, encoded_ack, dack_pin_in, extra_pci_grant0_n} <= {8'hFA, 3'h5, 8'hB7, 1'b0};
		step();
		chk("dack_low", s ? 16'h5 : 16'h2, 16'(dack_out_n[2:0]));
		chk("dack_pins", s ? 16'hDD58 : 16'hFA10, {dack_out_n, dack_oe_n});
		chk("extra_req", s ? 16'h0 : 16'h3, 16'({extra_pci_request0_n, extra_pci_request1_n}));
	endtask

	task automatic pci_case(input int ms, input int ph, input logic [8:0] b);
		logic ext, own, ap, dp, w, r, tw;
		{ext, own, ap, dp, w, r} = {ms == 1, ms == 2, ph == 1, ph == 2, b[0], b[1]};
		tw = (ext & w) | (own & r);
		@(posedge clk);
		{pci_addr_phase, pci_data_phase, ext_master_cycle, own_master_cycle} <= {ap, dp, ext, own};
		{ext_write, own_read, target_isa_or_cfg, target_claim_pos} <= {w, r, b[2], b[2]};
		{target_claim_sub, target_stop_req, data_parity_err, addr_parity_err} <= {b[3], b[4], b[5], b[6]};
		{special_cycle, fatal_err} <= {b[7], b[8]};
		step();
		chk("ad_oe_n", 16'(ap ? ext : dp & tw), 16'(ad_oe_n));
		chk("cbe_oe_n", 16'(ext), 16'(cbe_oe_n));
		chk("par_oe_n", 16'((ext & (ap | (dp & w))) | (own & dp & r)), 16'(par_oe_n));
		chk("frame_irdy", 16'({!own, !own}), 16'({frame_oe_n, irdy_oe_n}));
		chk("trdy_oe_n", 16'(!(ext & b[2])), 16'(trdy_oe_n));
		chk("stop_oe_n", 16'(!(ext & b[4])), 16'(stop_oe_n));
		chk("devsel_oe_n", 16'(!(ext & (b[2] | b[3]))), 16'(devsel_oe_n));
		chk("perr", 16'({!(dp & b[5] & !b[7] & tw), 1'b0}), 16'({perr_oe_n, perr_out_n}));
		chk("serr", 16'({!(b[6] | (b[5] & b[7]) | b[8]), 1'b0}), 16'({serr_oe_n, serr_out_n}));
		chk("lock_oe_n", 16'h1, 16'(lock_oe_n));
	endtask

	task automatic mux_case(input logic [7:0] c, input logic [7:0] i);
		logic v, s0, s1;
		s0 = |i[3:0];
		s1 = |i[7:4];
		wr(8'h52, c);
		wr(8'h43, i);
		rd(8'h52, c, "bridge_ctrl");
		rd(8'h43, i, "ide_timing");
		for (int k = 0; k < 2; k++) begin
			v = k[0];
			@(posedge clk);
			{chck_pin_n, nows_pin_n, drq7_pin, isa_reset_drive, power_latch_enable} <= {v, v, !v, v, !v};
			{drive_read_strobe_n, drive_write_strobe_n} <= {v, !v};
			{ide_cable0_buffer_en_n, ide_cable1_buffer_en_n} <= {!v, v};
			{aen_in, slot1_address_enable, slot2_address_enable, slot3_address_enable} <= {v, !v, v, !v};
			step();
			chk("rstdrv_pin", 16'(c[7] ? !v : v), 16'(rstdrv_pin));
			chk("chck_mux", 16'(c[3] ? {v, 1'b1} : {1'b1, v}), 16'({hot_drive_insert_n, chan_check_n}));
			chk("nows_mux", 16'(s0 ? {!v, 1'b1} : {1'b0, v}), 16'({ide_cable0_dma_request, no_wait_n}));
			chk("drq7_mux", 16'(s1 ? {!v, 1'b0} : {1'b0, !v}), 16'({ide_cable1_dma_request, dreq7}));
			chk("strobes", 16'({c[4] ? !v : v, c[4] ? v : !v}), 16'({strobe0_pin, strobe1_pin}));
			chk("strobe_oe_n", 16'h0, 16'(strobe_oe_n));
			chk("slot_aen", 16'(c[6] ? {!v, v, !v} : {v, 2'b11}), 16'({aen_pin, dack_out_n[7:6]}));
		end
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("[ERR] watchdog expected end seen hang");
		summarize();
	end

	initial begin
		strap_case(1'b0);
		rd(8'h52, 8'h00, "ctrl_reset");
		rd(8'h43, 8'h00, "ide_reset");
		rd(8'h60, 8'h86, "status");
		step();
		chk("rdata_idle", 16'h0, 16'(reg_rdata));
		@(posedge clk);
		idsel <= 1'b0;
		wr(8'h52, 8'hFF);
		rd(8'h52, 8'h00, "rd_no_idsel");
		@(posedge clk);
		idsel <= 1'b1;
		rd(8'h52, 8'h00, "wr_no_idsel");
		wr(8'h11, 8'hFF);
		rd(8'h11, 8'h00, "unmapped");
		// Claims and stop only make sense as target of an outside master
		for (int m = 0; m < 9; m++) begin
			for (int b = 0; b < 512; b++) begin
				if ((m / 3 != 1 && b[4:2] != 0) || (m / 3 == 1 && b[3:2] == 0) || (b[4] && !b[2])) continue;
				pci_case(m / 3, m % 3, 9'(b));
			end
		end
		@(posedge clk);
		dma_mem_need <= 1'b1;
		step();
		chk("req_dma", 16'h0, 16'(req_n));
		n = 0;
		while (bus_owned !== 1'b1 && n < 10) begin
			step();
			n++;
		end
		chk("bus_owned", 16'h1, 16'(bus_owned));
		@(posedge clk);
		{dma_mem_need, driveback_need} <= 2'b01;
		step();
		chk("req_drvback", 16'h0, 16'(req_n));
		@(posedge clk);
		driveback_need <= 1'b0;
		step();
		chk("req_idle", 16'h1, 16'(req_n));
		@(posedge clk);
		{stop_pending, clock_keep_req} <= 2'b11;
		n = 0;
		while (clkrun_oe_n !== 1'b0 && n < 10) begin
			step();
			n++;
		end
		n = 0;
		while (clkrun_oe_n === 1'b0 && n < 10) begin
			step();
			n++;
		end
		chk("clkrun_hold", 16'(`PIB_CLKRUN_HOLD_CYC), 16'(n));
		@(posedge clk);
		{stop_pending, clock_keep_req} <= 2'b00;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{isa_ext_master, power_latch_cycle, power_latch_bits, isa_addr_low} <= {k[0], k[1], 16'hA5C3, 16'h3C5A};
			step();
			chk("sa_dir", 16'(!k[1] & k[0]), 16'(sa_oe_n));
			if (sa_oe_n === 1'b0) chk("sa_low", k[1] ? 16'hA5C3 : 16'h3C5A, sa_low_out);
		end
		for (int k = 0; k < 9; k++) mux_case(cfg52[k], cfg43[k]);
		strap_case(1'b1);
		rd(8'h60, 8'hC6, "status_ext");
		summarize();
	end
endmodule // pib_pin_control_tb
`default_nettype wire
